// file: pkg/pmi_regs.vh
// Register map, field layout, reset values and timing of the event block
`ifndef PMI_REGS_VH
`define PMI_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PMI_ADDR_STATUS_0   8'h05
`define PMI_ADDR_MASK_0     8'h06
`define PMI_ADDR_LEVEL_0    8'h07
`define PMI_ADDR_STATUS_1   8'h08
`define PMI_ADDR_MASK_1     8'h09
`define PMI_ADDR_LEVEL_1    8'h0A
`define PMI_ADDR_STATUS_3   8'h0E
`define PMI_ADDR_MASK_3     8'h0F

// ----------------------------------------------------------------------
// Implemented bits of each status and mask register
// ----------------------------------------------------------------------
`define PMI_STAT0_BITS      8'h3F
`define PMI_STAT1_BITS      8'h1B
`define PMI_STAT3_BITS      8'hC1
`define PMI_MASK0_BITS      8'h3F
`define PMI_MASK1_BITS      8'h7F
`define PMI_MASK3_BITS      8'hC5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PMI_STAT_RESET      8'h00
`define PMI_MASK0_RESET     8'h3F
`define PMI_MASK1_RESET     8'h7F
`define PMI_MASK3_RESET     8'hC5
`define PMI_RDATA_RESET     8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PMI_BIT_BUTTON      0
`define PMI_BIT_LOW_SUPPLY  1
`define PMI_BIT_TEMP_T1     2
`define PMI_BIT_STRAP       6
`define PMI_BIT_FUSE_PIN    7
`define PMI_BIT_BUCK_A0     0
`define PMI_BIT_BUCK_A1     1
`define PMI_BIT_BUCK_A_LVL  2
`define PMI_BIT_BUCK_B      3
`define PMI_BIT_BUCK_C      4
`define PMI_BIT_BOOST       0
`define PMI_BIT_BLOW_DONE   6
`define PMI_BIT_FUSE_ERR    7

// ----------------------------------------------------------------------
// Event source indices and trigger edges
// ----------------------------------------------------------------------
`define PMI_NUM_SRC         12
`define PMI_SRC_BUTTON      0
`define PMI_SRC_LOW_SUPPLY  1
`define PMI_SRC_TEMP_T1     2
`define PMI_SRC_TEMP_T4     5
`define PMI_SRC_BUCK_A      6
`define PMI_SRC_BUCK_B      7
`define PMI_SRC_BUCK_C      8
`define PMI_SRC_BOOST       9
`define PMI_SRC_FUSE_ERR    10
`define PMI_SRC_BLOW_DONE   11
`define PMI_RISE_MASK       12'hFFE
`define PMI_FALL_MASK       12'h03D

// ----------------------------------------------------------------------
// Timing: clock period, tick period, debounce times in microseconds
// ----------------------------------------------------------------------
`define PMI_CLK_PERIOD_NS   4
`define PMI_TICK_NS         1000
`define PMI_DBNC_LOW_US     3900
`define PMI_DBNC_BUTTON_US  31250
`define PMI_DBNC_TEMP_US    3900
`define PMI_DBNC_OC_US      8000
`define PMI_CNT_W           18

// ----------------------------------------------------------------------
// Timing counts: tick cycles per tick and debounce lengths in ticks
// ----------------------------------------------------------------------
`define PMI_TICK_CYCLES         8'hFA
`define PMI_DBNC_LOW_TICKS      18'h00F3C
`define PMI_DBNC_BUTTON_TICKS   18'h07A12
`define PMI_DBNC_TEMP_TICKS     18'h00F3C
`define PMI_DBNC_OC_TICKS       18'h01F40

`endif

// file: logic/pmi_debounce.v
// Debounce filter for one event source with edge-selected event pulse
`timescale 1ns/1ps

module pmi_debounce (
    mclk,
    rst_n,
    tick,
    raw_in,
    limit,
    rise_en,
    fall_en,
    event_pulse
);
    input  wire        mclk;
    input  wire        rst_n;
    input  wire        tick;
    input  wire        raw_in;
    input  wire [17:0] limit;
    input  wire        rise_en;
    input  wire        fall_en;
    output reg         event_pulse;

    reg        level;
    reg [17:0] cnt;

    // --------------------------------------------------------------
    // Filter
    // --------------------------------------------------------------
    // Count ticks while raw differs from the accepted level
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            level       <= 1'b0;
            cnt         <= 18'h00000;
            event_pulse <= 1'b0;
        end else begin
            event_pulse <= 1'b0;
            if (raw_in == level) begin
                cnt <= 18'h00000;
            end else if (cnt >= limit) begin
                level       <= raw_in;
                cnt         <= 18'h00000;
                event_pulse <= raw_in ? rise_en : fall_en;
            end else if (tick) begin
                cnt <= cnt + 18'h00001;
            end
        end
    end

endmodule

// file: logic/pmi_event_top.v
// Event flag, mask and level registers with the active-low interrupt pin
// Operation
// - Low supply latches after 3.9 ms debounce; level is 1 below 2.70 V.
// - Button falling edge latches after 31.25 ms; level follows button.
// - Two-bit select lengthens button and low-supply debounce.
// - Four thermal thresholds latch on either edge after 3.9 ms.
// - Regulator overcurrent latches on rising limit after 8.0 ms.
// - Fuse error latches on rising detect with no debounce.
// - Fuse auto-blow completion latches on rising edge, no debounce.
// - Status 0 at 0x05 holds button, supply and thermal W1C flags.
// - Mask 0 at 0x06 bits 0 to 5 reset masked.
// - Level 0 at 0x07 shows button, supply, thermal, strap, fuse pin.
// - Status 1 at 0x08 holds buck W1C flags in bits 0,1,3,4.
// - Mask 1 at 0x09 bits 0 to 6 reset to 1, bit 7 zero.
// - Level 1 at 0x0A shows buck levels in bits 0,2,3,4.
// - Status 3 at 0x0E holds boost, blow done, fuse error flags.
// - Mask 3 at 0x0F bits 0,2,6,7 reset to 1.
// - Flags stay set until written 1; pin low on unmasked flag.
// - Pin stays low across clears with new events; unmask asserts.
// - Sources must hold stable through debounce; levels are live.
`timescale 1ns/1ps
`include "pmi_regs.vh"

module pmi_event_top (
    mclk,
    rst_n,
    button_in,
    low_supply_in,
    temp_in,
    buck_a_oc_in,
    buck_b_oc_in,
    buck_c_oc_in,
    boost_oc_in,
    fuse_error_in,
    fuse_blow_done_in,
    test_strap_in,
    fuse_supply_pin_in,
    button_debounce_sel,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    irq_out_n
);
    // Tick counts are sized so no bits are cut at the parameter
    parameter [17:0] DBNC_LOW_TICKS    = `PMI_DBNC_LOW_TICKS;
    parameter [17:0] DBNC_BUTTON_TICKS =
        `PMI_DBNC_BUTTON_TICKS;
    parameter [17:0] DBNC_TEMP_TICKS   = `PMI_DBNC_TEMP_TICKS;
    parameter [17:0] DBNC_OC_TICKS     = `PMI_DBNC_OC_TICKS;
    parameter [7:0]  TICK_CYCLES       = `PMI_TICK_CYCLES;

    input  wire       mclk;
    input  wire       rst_n;
    input  wire       button_in;
    input  wire       low_supply_in;
    input  wire [3:0] temp_in;
    input  wire       buck_a_oc_in;
    input  wire       buck_b_oc_in;
    input  wire       buck_c_oc_in;
    input  wire       boost_oc_in;
    input  wire       fuse_error_in;
    input  wire       fuse_blow_done_in;
    input  wire       test_strap_in;
    input  wire       fuse_supply_pin_in;
    input  wire [1:0] button_debounce_sel;
    input  wire [7:0] reg_addr;
    input  wire [7:0] reg_wdata;
    input  wire       reg_wr;
    input  wire       reg_rd;
    output reg  [7:0] reg_rdata;
    output reg        irq_out_n;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg  [7:0] tick_cnt;
    reg        tick;
    reg  [7:0] event_status_0;
    reg  [7:0] event_mask_0;
    reg  [7:0] event_status_1;
    reg  [7:0] event_mask_1;
    reg  [7:0] event_status_3;
    reg  [7:0] event_mask_3;
    reg  [7:0] next_rdata;
    reg  [7:0] next_status_0;
    reg  [7:0] next_status_1;
    reg  [7:0] next_status_3;
    reg  [7:0] clr_0;
    reg  [7:0] clr_1;
    reg  [7:0] clr_3;
    wire [`PMI_NUM_SRC-1:0] raw_src;
    wire [`PMI_NUM_SRC-1:0] evt;
    wire [`PMI_NUM_SRC-1:0] rise_mask;
    wire [`PMI_NUM_SRC-1:0] fall_mask;
    wire [7:0] event_level_0;
    wire [7:0] event_level_1;
    wire [7:0] set_0;
    wire [7:0] set_1;
    wire [7:0] set_3;
    wire       pending;

    // ------------------------------------------------------------------
    // Debounce length per source
    // ------------------------------------------------------------------
    function [17:0] dbnc_limit;
        input integer idx;
        input [1:0] sel;
        begin
            if (idx == `PMI_SRC_BUTTON) begin
                dbnc_limit = DBNC_BUTTON_TICKS << sel;
            end else if (idx == `PMI_SRC_LOW_SUPPLY) begin
                dbnc_limit = DBNC_LOW_TICKS << sel;
            end else if (idx <= `PMI_SRC_TEMP_T4) begin
                dbnc_limit = DBNC_TEMP_TICKS;
            end else if (idx <= `PMI_SRC_BOOST) begin
                dbnc_limit = DBNC_OC_TICKS;
            end else begin
                dbnc_limit = 18'h00000;
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Address match used by the flag-clear and mask write paths
    // ------------------------------------------------------------------
    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // ------------------------------------------------------------------
    // Slow tick
    // ------------------------------------------------------------------
    // One-cycle tick every TICK_CYCLES clocks
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 8'h00;
            tick     <= 1'b0;
        end else if (tick_cnt == TICK_CYCLES - 8'h01) begin
            tick_cnt <= 8'h00;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 8'h01;
            tick     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------------
    // Source vector in index order
    assign raw_src = {fuse_blow_done_in, fuse_error_in, boost_oc_in,
                      buck_c_oc_in, buck_b_oc_in, buck_a_oc_in,
                      temp_in, low_supply_in, button_in};
    assign rise_mask = `PMI_RISE_MASK;
    assign fall_mask = `PMI_FALL_MASK;

    // One filter per source; edges pick the trigger direction
    genvar gi;
    generate
        for (gi = 0; gi < `PMI_NUM_SRC; gi = gi + 1) begin : g_src
            pmi_debounce u_dbnc (
                .mclk        (mclk),
                .rst_n       (rst_n),
                .tick        (tick),
                .raw_in      (raw_src[gi]),
                .limit       (dbnc_limit(gi, button_debounce_sel)),
                .rise_en     (rise_mask[gi]),
                .fall_en     (fall_mask[gi]),
                .event_pulse (evt[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Flag set vectors
    // ------------------------------------------------------------------
    // Button, low supply and thermal events
    assign set_0 = {2'b00, evt[`PMI_SRC_TEMP_T4:`PMI_SRC_TEMP_T1],
                    evt[`PMI_SRC_LOW_SUPPLY], evt[`PMI_SRC_BUTTON]};
    // Buck A sets both of its bits
    assign set_1 = {3'b000, evt[`PMI_SRC_BUCK_C], evt[`PMI_SRC_BUCK_B], 1'b0,
                    evt[`PMI_SRC_BUCK_A], evt[`PMI_SRC_BUCK_A]};
    // Boost, blow done and fuse error
    assign set_3 = {evt[`PMI_SRC_FUSE_ERR], evt[`PMI_SRC_BLOW_DONE], 5'b00000,
                    evt[`PMI_SRC_BOOST]};

    // ------------------------------------------------------------------
    // Live level registers
    // ------------------------------------------------------------------
    // Raw levels, never latched
    assign event_level_0 = {fuse_supply_pin_in, test_strap_in, temp_in,
                            low_supply_in, button_in};
    assign event_level_1 = {3'b000, buck_c_oc_in, buck_b_oc_in, buck_a_oc_in,
                            1'b0, buck_a_oc_in};

    // ------------------------------------------------------------------
    // Write-one-to-clear and next flag values
    // ------------------------------------------------------------------
    // Set is ORed in after the clear so a same-cycle event wins
    always @* begin
        clr_0 = 8'h00;
        clr_1 = 8'h00;
        clr_3 = 8'h00;
        if (reg_wr && hit(reg_addr, `PMI_ADDR_STATUS_0)) begin
            clr_0 = reg_wdata;
        end
        if (reg_wr && hit(reg_addr, `PMI_ADDR_STATUS_1)) begin
            clr_1 = reg_wdata;
        end
        if (reg_wr && hit(reg_addr, `PMI_ADDR_STATUS_3)) begin
            clr_3 = reg_wdata;
        end
        next_status_0 = ((event_status_0 & ~clr_0) | set_0)
                        & `PMI_STAT0_BITS;
        next_status_1 = ((event_status_1 & ~clr_1) | set_1) & `PMI_STAT1_BITS;
        next_status_3 = ((event_status_3 & ~clr_3) | set_3) & `PMI_STAT3_BITS;
    end

    // Flag registers
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            event_status_0 <= `PMI_STAT_RESET;
            event_status_1 <= `PMI_STAT_RESET;
            event_status_3 <= `PMI_STAT_RESET;
        end else begin
            event_status_0 <= next_status_0;
            event_status_1 <= next_status_1;
            event_status_3 <= next_status_3;
        end
    end

    // ------------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------------
    // Plain read-write; unimplemented bits stay zero
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            event_mask_0 <= `PMI_MASK0_RESET;
            event_mask_1 <= `PMI_MASK1_RESET;
            event_mask_3 <= `PMI_MASK3_RESET;
        end else if (reg_wr) begin
            if (hit(reg_addr, `PMI_ADDR_MASK_0)) begin
                event_mask_0 <= reg_wdata & `PMI_MASK0_BITS;
            end
            if (hit(reg_addr, `PMI_ADDR_MASK_1)) begin
                event_mask_1 <= reg_wdata & `PMI_MASK1_BITS;
            end
            if (hit(reg_addr, `PMI_ADDR_MASK_3)) begin
                event_mask_3 <= reg_wdata & `PMI_MASK3_BITS;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------------
    // Any set and unmasked flag holds the pin low
    assign pending = |(event_status_0 & ~event_mask_0)
                   | |(event_status_1 & ~event_mask_1)
                   | |(event_status_3 & ~event_mask_3);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= ~pending;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Unmapped offsets read as zero
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `PMI_ADDR_STATUS_0: next_rdata = event_status_0;
            `PMI_ADDR_MASK_0:   next_rdata = event_mask_0;
            `PMI_ADDR_LEVEL_0:  next_rdata = event_level_0;
            `PMI_ADDR_STATUS_1: next_rdata = event_status_1;
            `PMI_ADDR_MASK_1:   next_rdata = event_mask_1;
            `PMI_ADDR_LEVEL_1:  next_rdata = event_level_1;
            `PMI_ADDR_STATUS_3: next_rdata = event_status_3;
            `PMI_ADDR_MASK_3:   next_rdata = event_mask_3;
            default:            next_rdata = 8'h00;
        endcase
    end

    // Read data captured on the read strobe and held until the next
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `PMI_RDATA_RESET;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

// file: tb/pmi_host_model.sv
// Host side register master for the block's byte access port
`timescale 1ns/1ps

module pmi_host_model (
    input  wire       mclk,
    input  wire [7:0] reg_rdata,
    output reg  [7:0] reg_addr,
    output reg  [7:0] reg_wdata,
    output reg        reg_wr,
    output reg        reg_rd
);
    // Idle port at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One write strobe; address and data scrambled once released
    task wr(input [7:0] a, input [7:0] d);
        @(negedge mclk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge mclk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    // One read strobe; data is taken after the sampling edge
    task rd(input [7:0] a, output [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge mclk);
        d        = reg_rdata;
        reg_rd   = 1'b0;
        reg_addr = ~a;
    endtask
endmodule

// file: tb/pmi_event_top_assertions.sv
// Port level checks of the event flag, mask and level block
`timescale 1ns/1ps

module pmi_event_checker (
    input wire       mclk,
    input wire       rst_n,
    input wire       button_in,
    input wire       low_supply_in,
    input wire [3:0] temp_in,
    input wire       buck_a_oc_in,
    input wire       buck_b_oc_in,
    input wire       buck_c_oc_in,
    input wire       boost_oc_in,
    input wire       fuse_error_in,
    input wire       fuse_blow_done_in,
    input wire       test_strap_in,
    input wire       fuse_supply_pin_in,
    input wire [1:0] button_debounce_sel,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       irq_out_n
);
    reg m3_err;
    reg wrote;

    // Shadow of the fuse error mask and of any write since reset
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            m3_err <= 1'b1;
            wrote  <= 1'b0;
        end else if (reg_wr) begin
            wrote <= 1'b1;
            if (reg_addr == 8'h0F) begin
                m3_err <= reg_wdata[7];
            end
        end
    end

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_RST_IDLE: assert property ($rose(rst_n) |->
        irq_out_n && reg_rdata == 8'h00) else $error("not idle at reset");
    AST_QUIET: assert property (!wrote |-> irq_out_n)
        else $error("pin low with all events masked");
    AST_HOLD: assert property (!irq_out_n && !reg_wr &&
        !$past(reg_wr) |=> !irq_out_n) else $error("pin released alone");
    AST_FUSE_IRQ: assert property ($rose(fuse_error_in) &&
        !m3_err && !reg_wr |-> ##[1:5] !irq_out_n)
        else $error("fuse error did not drive pin");
    AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    AST_UNMAPPED: assert property (reg_rd && !(reg_addr inside
        {8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0E, 8'h0F})
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    AST_LVL0: assert property (reg_rd && reg_addr == 8'h07 |=>
        reg_rdata == $past({fuse_supply_pin_in, test_strap_in, temp_in,
        low_supply_in, button_in})) else $error("level 0 wrong");
    AST_LVL1: assert property (reg_rd && reg_addr == 8'h0A |=>
        reg_rdata == $past({3'h0, buck_c_oc_in, buck_b_oc_in,
        buck_a_oc_in, 1'b0, buck_a_oc_in})) else $error("level 1 wrong");
endmodule

bind pmi_event_top pmi_event_checker u_chk (.mclk(mclk), .rst_n(rst_n),
    .button_in(button_in), .low_supply_in(low_supply_in),
    .temp_in(temp_in), .buck_a_oc_in(buck_a_oc_in),
    .buck_b_oc_in(buck_b_oc_in), .buck_c_oc_in(buck_c_oc_in),
    .boost_oc_in(boost_oc_in), .fuse_error_in(fuse_error_in),
    .fuse_blow_done_in(fuse_blow_done_in), .test_strap_in(test_strap_in),
    .fuse_supply_pin_in(fuse_supply_pin_in),
    .button_debounce_sel(button_debounce_sel), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_out_n(irq_out_n));

// file: tb/pmi_event_top_tb_top.sv
// Self-checking bench for the event flag, mask and level block
`timescale 1ns/1ps

module pmi_event_top_tb_top;
    localparam [7:0]  TK = 8'h04;
    localparam [17:0] LT = 18'h00003;
    localparam [17:0] BT = 18'h00005;
    localparam [17:0] TT = 18'h00003;
    localparam [17:0] OT = 18'h00004;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] src = 12'h001;
    logic        strap = 1'b0;
    logic        pin = 1'b0;
    logic [1:0]  sel = 2'b00;
    wire  [7:0]  reg_addr;
    wire  [7:0]  reg_wdata;
    wire  [7:0]  reg_rdata;
    wire         reg_wr;
    wire         reg_rd;
    wire         irq_out_n;
    int          failures = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          seed = 18;
    logic [7:0]  ma [3] = '{8'h06, 8'h09, 8'h0F};

    pmi_event_top #(.DBNC_LOW_TICKS(LT), .DBNC_BUTTON_TICKS(BT),
        .DBNC_TEMP_TICKS(TT), .DBNC_OC_TICKS(OT), .TICK_CYCLES(TK)) DUT (
        .mclk(mclk), .rst_n(rst_n), .button_in(src[0]),
        .low_supply_in(src[1]), .temp_in(src[5:2]),
        .buck_a_oc_in(src[6]), .buck_b_oc_in(src[7]), .buck_c_oc_in(src[8]),
        .boost_oc_in(src[9]), .fuse_error_in(src[10]),
        .fuse_blow_done_in(src[11]), .test_strap_in(strap),
        .fuse_supply_pin_in(pin), .button_debounce_sel(sel),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_out_n(irq_out_n));

    pmi_host_model u_host (.mclk(mclk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd));

    // Clock, and a ceiling far above the few thousand cycles needed
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    // Status address, flag bits and debounce ticks of each source
    function automatic logic [7:0] sa(input int i);
        return (i < 6) ? 8'h05 : (i < 9) ? 8'h08 : 8'h0E;
    endfunction
    function automatic logic [7:0] sb(input int i);
        case (i)
            6: return 8'h03;
            7: return 8'h08;
            8: return 8'h10;
            9: return 8'h01;
            10: return 8'h80;
            11: return 8'h40;
            default: return 8'h01 << i;
        endcase
    endfunction
    function automatic int dl(input int i);
        case (i)
            0: return int'(BT << sel);
            1: return int'(LT << sel);
            2, 3, 4, 5: return int'(TT);
            10, 11: return 0;
            default: return int'(OT);
        endcase
    endfunction
    // Reset value of a register, or live value of a level register
    function automatic logic [7:0] ex(input logic [7:0] a);
        case (a)
            8'h06: return 8'h3F;
            8'h07: return {pin, strap, src[5:0]};
            8'h09: return 8'h7F;
            8'h0A: return {3'h0, src[8:6], 1'b0, src[6]};
            8'h0F: return 8'hC5;
            default: return 8'h00;
        endcase
    endfunction

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] s);
        n_tests++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, s);
            failures++;
        end
    endtask
    task automatic rc(input string n, input logic [7:0] a,
                      input logic [7:0] e);
        logic [7:0] v;
        u_host.rd(a, v);
        chk(n, e, v);
    endtask
    task automatic cy(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Drive one source to its trigger, check timing, clear, then revert
    task automatic fire(input int i);
        logic [7:0] a;
        logic [7:0] b;
        int         t;
        a = sa(i);
        b = sb(i);
        t = dl(i);
        u_host.wr(a + 8'h01, 8'h00);
        @(negedge mclk);
        src[i] = ~src[i];
        if (t > 1) begin
            cy((t - 1) * TK - 6);
            rc("early", a, 8'h00);
        end
        cy(3 * TK + 8);
        rc("flag", a, b);
        chk("irq", 8'h00, {7'h00, irq_out_n});
        u_host.wr(a, 8'h00);
        rc("keep", a, b);
        u_host.wr(a, b);
        cy(3);
        rc("clear", a, 8'h00);
        chk("irq", 8'h01, {7'h00, irq_out_n});
        src[i] = ~src[i];
        cy(t * TK + 3 * TK + 8);
        rc("revert", a, (i > 1 && i < 6) ? b : 8'h00);
        u_host.wr(a, b);
        u_host.wr(a + 8'h01, 8'hFF);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [7:0] v;
        cy(4);
        rst_n = 1'b1;
        for (int a = 0; a <= 16; a++) begin
            rc("reset", 8'(a), ex(8'(a)));
        end
        rc("reset", 8'hFF, 8'h00);
        $display("test reset done");
        foreach (ma[j]) begin
            v = 8'($random(seed));
            u_host.wr(ma[j], v);
            rc("mask", ma[j], v & ex(ma[j]));
            u_host.wr(ma[j], 8'hFF);
        end
        u_host.wr(8'h07, 8'hFF);
        rc("level", 8'h07, ex(8'h07));
        $display("test masks done");
        repeat (8) begin
            @(negedge mclk);
            {pin, strap, src[9:0]} = 12'($random(seed));
            sel = 2'($random(seed));
            rc("level0", 8'h07, ex(8'h07));
            rc("level1", 8'h0A, ex(8'h0A));
        end
        src = 12'h001;
        cy(400);
        foreach (ma[j]) begin
            u_host.wr(ma[j] - 8'h01, 8'hFF);
            rc("flush", ma[j] - 8'h01, 8'h00);
        end
        $display("test levels done");
        for (int i = 0; i < 12; i++) begin
            sel = 2'($random(seed));
            fire(i);
        end
        $display("test events done");
        repeat (3) begin
            src[6] = 1'b1;
            cy(TK);
            src[6] = 1'b0;
            cy(2 * TK);
        end
        cy(6 * TK);
        rc("glitch", 8'h08, 8'h00);
        $display("test glitch done");
        for (int k = 0; k < 2; k++) begin
            // Event lands with the clear (k=0) or one edge after it (k=1)
            fork
                u_host.wr(8'h0E, 8'h80);
                begin
                    cy(k);
                    src[10] = 1'b1;
                end
            join
            cy(4);
            rc("race", 8'h0E, 8'h80);
            chk("irq", 8'h01, {7'h00, irq_out_n});
            src[10] = 1'b0;
            cy(4);
            rc("sticky", 8'h0E, 8'h80);
            u_host.wr(8'h0F, 8'h7F);
            cy(3);
            chk("irq", 8'h00, {7'h00, irq_out_n});
            u_host.wr(8'h0E, 8'h80);
            cy(3);
            chk("irq", 8'h01, {7'h00, irq_out_n});
            u_host.wr(8'h0F, 8'hFF);
        end
        $display("test race done");
        rst_n = 1'b0;
        cy(2);
        rst_n = 1'b1;
        rc("rereset", 8'h06, 8'h3F);
        $display("test rereset done");
        tally_and_finish();
    end
endmodule
